// ===== dfdma_pkg.sv
package dfdma_pkg;

  // ----------------------------------------------------------------
  // io decode windows
  // ----------------------------------------------------------------
  localparam logic [9:0] DFDMA_C1_BASE = 10'h000;
  localparam logic [9:0] DFDMA_C2_BASE = 10'h0C0;
  localparam logic [9:0] DFDMA_C2_LAST = 10'h0DE;

  // ----------------------------------------------------------------
  // register indices inside one controller
  // ----------------------------------------------------------------
  localparam logic [3:0] DFDMA_REG_STAT_CMD = 4'h8;
  localparam logic [3:0] DFDMA_REG_REQUEST = 4'h9;
  localparam logic [3:0] DFDMA_REG_ONE_MASK = 4'hA;
  localparam logic [3:0] DFDMA_REG_MODE = 4'hB;
  localparam logic [3:0] DFDMA_REG_PTR_CLR = 4'hC;
  localparam logic [3:0] DFDMA_REG_REINIT = 4'hD;
  localparam logic [3:0] DFDMA_REG_UNMASK = 4'hE;
  localparam logic [3:0] DFDMA_REG_ALL_MASK = 4'hF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DFDMA_CMD_DISABLE = 2;
  localparam int DFDMA_CMD_B3 = 3;
  localparam int DFDMA_CMD_ROTATE = 4;
  localparam int DFDMA_CMD_EXTW = 5;
  localparam int DFDMA_REQ_SET = 2;
  localparam int DFDMA_MASK_SET = 2;
  localparam int DFDMA_MODE_TT = 2;
  localparam int DFDMA_MODE_AUTO = 4;
  localparam int DFDMA_MODE_DEC = 5;
  localparam int DFDMA_MODE_MD = 6;

  // synchronised control pin positions
  localparam int DFDMA_CTL_RD = 0;
  localparam int DFDMA_CTL_WR = 1;
  localparam int DFDMA_CTL_RFSH = 2;
  localparam int DFDMA_CTL_MASTER = 3;
  localparam int DFDMA_CTL_HACK = 4;

  // ----------------------------------------------------------------
  // reset values and counter constants
  // ----------------------------------------------------------------
  localparam logic [7:0] DFDMA_CMD_RESET = 8'h00;
  localparam logic [3:0] DFDMA_MASK_RESET = 4'hF;
  localparam logic [4:0] DFDMA_CTL_RESET = 5'h07;
  localparam logic [15:0] DFDMA_CNT_LAST = 16'h0000;
  localparam logic [15:0] DFDMA_STEP = 16'h0001;
  localparam logic [8:0] DFDMA_RFSH_STEP = 9'h001;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DFDMA_TT_VERIFY = 2'b00,
    DFDMA_TT_WRITE = 2'b01,
    DFDMA_TT_READ = 2'b10
  } dfdma_ttype_t;

  typedef enum logic [1:0] {
    DFDMA_MD_DEMAND = 2'b00,
    DFDMA_MD_SINGLE = 2'b01,
    DFDMA_MD_BLOCK = 2'b10,
    DFDMA_MD_CASCADE = 2'b11
  } dfdma_mode_t;

  typedef enum logic [2:0] {
    DFDMA_ST_IDLE = 3'b000,
    DFDMA_ST_HOLD = 3'b001,
    DFDMA_ST_ADDR = 3'b010,
    DFDMA_ST_STB1 = 3'b011,
    DFDMA_ST_STB2 = 3'b100,
    DFDMA_ST_CASC = 3'b101
  } dfdma_state_t;

endpackage

// ===== dfdma_top.sv
`timescale 1ns/1ps

module dfdma_top
  import dfdma_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host io register port
  input wire logic [9:0] i_io_addr,
  input wire logic [7:0] i_io_data,
  input wire logic i_io_read_n,
  input wire logic i_io_write_n,
  output logic [7:0] o_io_data,
  output logic o_io_data_oe,
  // peripheral handshake
  input wire logic [7:0] i_channel_request,
  output logic [7:0] o_channel_acknowledge,
  output logic o_terminal_count,
  // system bus control
  output logic o_hold_request,
  input wire logic i_hold_ack,
  input wire logic i_bus_master,
  input wire logic i_refresh_cycle_n,
  // address and strobes
  output logic [15:0] o_address,
  output logic o_address_oe,
  output logic o_io_read_strobe_n,
  output logic o_io_write_strobe_n,
  output logic o_memory_read_strobe_n,
  output logic o_memory_write_strobe_n,
  output logic o_strobe_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] req_s1;
    logic [7:0] req_s2;
    logic [4:0] ctl_s1;
    logic [4:0] ctl_s2;
    logic [17:0] bus_s1;
    logic [17:0] bus_s2;
    logic rd_prev;
    logic wr_prev;
    logic rfsh_prev;
    logic [7:0][15:0] base_addr;
    logic [7:0][15:0] cur_addr;
    logic [7:0][15:0] base_cnt;
    logic [7:0][15:0] cur_cnt;
    logic [7:0][7:0] mode;
    logic [1:0][7:0] cmd;
    logic [7:0] tc_flag;
    logic [7:0] sw_req;
    logic [7:0] mask;
    logic [7:0] wait_low;
    logic [1:0] ptr;
    logic [1:0][1:0] last;
    logic [8:0] rfsh_cnt;
    dfdma_state_t st;
    logic [2:0] chan;
    logic [7:0] io_data;
    logic io_data_oe;
    logic [7:0] ack;
    logic tc_out;
    logic hold_req;
    logic [15:0] addr;
    logic addr_oe;
    logic ior_n;
    logic iow_n;
    logic memory_read_strobe_n;
    logic memory_write_strobe_n;
    logic stb_oe;
  } dfdma_regs_t;

  function automatic dfdma_regs_t dfdma_rst_val();
    dfdma_regs_t r;
    r = '0;
    r.ctl_s1 = DFDMA_CTL_RESET;
    r.ctl_s2 = DFDMA_CTL_RESET;
    r.rd_prev = 1'b1;
    r.wr_prev = 1'b1;
    r.rfsh_prev = 1'b1;
    r.mask = {DFDMA_MASK_RESET, DFDMA_MASK_RESET};
    r.cmd = {DFDMA_CMD_RESET, DFDMA_CMD_RESET};
    r.ior_n = 1'b1;
    r.iow_n = 1'b1;
    r.memory_read_strobe_n = 1'b1;
    r.memory_write_strobe_n = 1'b1;
    return r;
  endfunction

  localparam dfdma_regs_t RST_Q = dfdma_rst_val();

  // winner among four requests, lowest offset from the start point wins
  function automatic logic [2:0] dfdma_pick(input logic [3:0] p, input logic rot,
                                            input logic [1:0] last);
    logic [2:0] r;
    logic [1:0] j;
    r = 3'h0;
    j = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      j = rot ? 2'(last + 2'(k + 1)) : 2'(k);
      if (p[j]) begin
        r = {1'b1, j};
      end
    end
    return r;
  endfunction

  dfdma_regs_t q;
  dfdma_regs_t n;

  // ----------------------------------------------------------------
  // decode of the synchronised host port
  // ----------------------------------------------------------------
  logic [9:0] io_addr;
  logic [7:0] io_dat;
  logic rd_n;
  logic wr_n;
  logic rfsh_n;
  logic master;
  logic hack;
  logic rd_fall;
  logic wr_fall;
  logic sel1;
  logic sel2;
  logic hit;
  logic ctl;
  logic [3:0] idx;
  logic [2:0] rch;

  assign io_addr = q.bus_s2[17:8];
  assign io_dat = q.bus_s2[7:0];
  assign rd_n = q.ctl_s2[DFDMA_CTL_RD];
  assign wr_n = q.ctl_s2[DFDMA_CTL_WR];
  assign rfsh_n = q.ctl_s2[DFDMA_CTL_RFSH];
  assign master = q.ctl_s2[DFDMA_CTL_MASTER];
  assign hack = q.ctl_s2[DFDMA_CTL_HACK];
  assign rd_fall = q.rd_prev & ~rd_n;
  assign wr_fall = q.wr_prev & ~wr_n;
  assign sel1 = io_addr[9:4] == DFDMA_C1_BASE[9:4];
  assign sel2 = (io_addr[9:5] == DFDMA_C2_BASE[9:5]) && !io_addr[0] &&
                (io_addr <= DFDMA_C2_LAST);
  assign hit = sel1 | sel2;
  assign ctl = sel2;
  assign idx = sel2 ? io_addr[4:1] : io_addr[3:0];
  assign rch = {ctl, idx[2:1]};

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [7:0] pend;
  logic [2:0] win1;
  logic [2:0] win2;
  logic any_pend;
  logic [2:0] pick_ch;

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      pend[c] = ((q.req_s2[c] & ~q.mask[c] & ~q.wait_low[c]) | q.sw_req[c]) &
                ~q.cmd[c / 4][DFDMA_CMD_DISABLE];
    end
    win1 = dfdma_pick(pend[3:0], q.cmd[0][DFDMA_CMD_ROTATE], q.last[0]);
    // 8-bit controller requests reach the bus through channel 4
    if (q.mode[4][DFDMA_MODE_MD +: 2] == DFDMA_MD_CASCADE && win1[2] && !q.mask[4] &&
        !q.cmd[1][DFDMA_CMD_DISABLE]) begin
      pend[4] = 1'b1;
    end
    // fixed or rotating, 16-bit controller first
    win2 = dfdma_pick(pend[7:4], q.cmd[1][DFDMA_CMD_ROTATE], q.last[1]);
    any_pend = win2[2];
    if (win2[1:0] == 2'b00 && win1[2] &&
        q.mode[4][DFDMA_MODE_MD +: 2] == DFDMA_MD_CASCADE) begin
      pick_ch = {1'b0, win1[1:0]};
    end else begin
      pick_ch = {1'b1, win2[1:0]};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [7:0] cm;
  logic [1:0] ch_tt;
  logic [1:0] ch_md;
  logic extw;
  logic at_tc;
  logic go_on;

  assign cm = q.mode[q.chan];
  assign ch_tt = cm[DFDMA_MODE_TT +: 2];
  assign ch_md = cm[DFDMA_MODE_MD +: 2];
  // extended write only with bit 3 clear
  assign extw = q.cmd[q.chan[2]][DFDMA_CMD_EXTW] & ~q.cmd[q.chan[2]][DFDMA_CMD_B3];
  assign at_tc = q.cur_cnt[q.chan] == DFDMA_CNT_LAST;

  always_comb begin
    n = q;
    go_on = 1'b0;
    // pins pass two flops before use; host bus held stable across strobe
    n.req_s1 = i_channel_request;
    n.req_s2 = q.req_s1;
    n.ctl_s1 = {i_hold_ack, i_bus_master, i_refresh_cycle_n, i_io_write_n, i_io_read_n};
    n.ctl_s2 = q.ctl_s1;
    n.bus_s1 = {i_io_addr, i_io_data};
    n.bus_s2 = q.bus_s1;
    n.rd_prev = rd_n;
    n.wr_prev = wr_n;
    n.rfsh_prev = rfsh_n;
    n.tc_out = 1'b0;
    n.ior_n = 1'b1;
    n.iow_n = 1'b1;
    n.memory_read_strobe_n = 1'b1;
    n.memory_write_strobe_n = 1'b1;
    n.stb_oe = 1'b0;
    n.addr_oe = 1'b0;

    // ----------------------------------------------------------------
    // host writes
    // ----------------------------------------------------------------
    if (wr_fall && hit) begin
      if (!idx[3]) begin
        if (idx[0]) begin
          n.base_cnt[rch][q.ptr[ctl] * 8 +: 8] = io_dat;
          n.cur_cnt[rch][q.ptr[ctl] * 8 +: 8] = io_dat;
        end else begin
          n.base_addr[rch][q.ptr[ctl] * 8 +: 8] = io_dat;
          n.cur_addr[rch][q.ptr[ctl] * 8 +: 8] = io_dat;
        end
        n.ptr[ctl] = ~q.ptr[ctl];
      end else begin
        case (idx)
          DFDMA_REG_STAT_CMD: begin
            n.cmd[ctl] = io_dat;
          end
          DFDMA_REG_REQUEST: begin
            n.sw_req[{ctl, io_dat[1:0]}] = io_dat[DFDMA_REQ_SET];
          end
          DFDMA_REG_ONE_MASK: begin
            n.mask[{ctl, io_dat[1:0]}] = io_dat[DFDMA_MASK_SET];
          end
          DFDMA_REG_MODE: begin
            n.mode[{ctl, io_dat[1:0]}] = io_dat;
          end
          DFDMA_REG_PTR_CLR: begin
            n.ptr[ctl] = 1'b0;
          end
          DFDMA_REG_REINIT: begin
            n.cmd[ctl] = DFDMA_CMD_RESET;
            n.ptr[ctl] = 1'b0;
            for (int i = 0; i < 4; i++) begin
              n.tc_flag[{ctl, 2'(i)}] = 1'b0;
              n.sw_req[{ctl, 2'(i)}] = 1'b0;
              n.mask[{ctl, 2'(i)}] = DFDMA_MASK_RESET[i];
            end
          end
          DFDMA_REG_UNMASK: begin
            for (int i = 0; i < 4; i++) begin
              n.mask[{ctl, 2'(i)}] = 1'b0;
            end
          end
          DFDMA_REG_ALL_MASK: begin
            for (int i = 0; i < 4; i++) begin
              n.mask[{ctl, 2'(i)}] = io_dat[i];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // ----------------------------------------------------------------
    // host reads
    // ----------------------------------------------------------------
    n.io_data_oe = ~rd_n & hit;
    if (rd_fall && hit) begin
      if (!idx[3]) begin
        // reads toggle the pointer as well
        n.io_data = idx[0] ? q.cur_cnt[rch][q.ptr[ctl] * 8 +: 8] :
                             q.cur_addr[rch][q.ptr[ctl] * 8 +: 8];
        n.ptr[ctl] = ~q.ptr[ctl];
      end else if (idx == DFDMA_REG_STAT_CMD) begin
        for (int i = 0; i < 4; i++) begin
          n.io_data[i] = q.tc_flag[{ctl, 2'(i)}];
          n.io_data[i + 4] = q.req_s2[{ctl, 2'(i)}];
          n.tc_flag[{ctl, 2'(i)}] = 1'b0;
        end
      end else begin
        n.io_data = 8'h00;
      end
    end

    if (!q.rfsh_prev && rfsh_n) begin
      n.rfsh_cnt = q.rfsh_cnt + DFDMA_RFSH_STEP;
    end

    // single mode re-arms once request drops
    for (int c = 0; c < 8; c++) begin
      if (!q.req_s2[c]) begin
        n.wait_low[c] = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // transfer engine
    // ----------------------------------------------------------------
    case (q.st)
      DFDMA_ST_IDLE: begin
        // refresh address when bus is otherwise idle
        if (!rfsh_n) begin
          n.addr = {7'h00, q.rfsh_cnt};
          n.addr_oe = 1'b1;
        end
        if (any_pend) begin
          n.hold_req = 1'b1;
          n.chan = pick_ch;
          n.st = DFDMA_ST_HOLD;
        end
      end
      DFDMA_ST_HOLD: begin
        if (hack) begin
          n.ack[q.chan] = 1'b1;
          n.last[q.chan[2]] = q.chan[1:0];
          if (!q.chan[2]) begin
            n.last[1] = 2'b00;
          end
          n.st = (ch_md == DFDMA_MD_CASCADE) ? DFDMA_ST_CASC : DFDMA_ST_ADDR;
        end
      end
      DFDMA_ST_ADDR: begin
        n.addr = q.cur_addr[q.chan];
        n.addr_oe = 1'b1;
        n.stb_oe = 1'b1;
        // read: memory to io; write: io to memory; verify: none
        // write strobe starts early only when extended
        n.memory_read_strobe_n = ~(ch_tt == DFDMA_TT_READ);
        n.ior_n = ~(ch_tt == DFDMA_TT_WRITE);
        n.iow_n = ~(ch_tt == DFDMA_TT_READ && extw);
        n.memory_write_strobe_n = ~(ch_tt == DFDMA_TT_WRITE && extw);
        n.st = DFDMA_ST_STB1;
      end
      DFDMA_ST_STB1: begin
        n.addr_oe = 1'b1;
        n.stb_oe = 1'b1;
        n.memory_read_strobe_n = ~(ch_tt == DFDMA_TT_READ);
        n.ior_n = ~(ch_tt == DFDMA_TT_WRITE);
        n.iow_n = ~(ch_tt == DFDMA_TT_READ);
        n.memory_write_strobe_n = ~(ch_tt == DFDMA_TT_WRITE);
        n.st = DFDMA_ST_STB2;
      end
      DFDMA_ST_STB2: begin
        n.cur_cnt[q.chan] = q.cur_cnt[q.chan] - DFDMA_STEP;
        n.cur_addr[q.chan] = cm[DFDMA_MODE_DEC] ? q.cur_addr[q.chan] - DFDMA_STEP :
                                                  q.cur_addr[q.chan] + DFDMA_STEP;
        if (at_tc) begin
          // wrap gives terminal count; flag set wins over a clear
          n.tc_out = 1'b1;
          n.tc_flag[q.chan] = 1'b1;
          n.sw_req[q.chan] = 1'b0;
          if (cm[DFDMA_MODE_AUTO]) begin
            n.cur_cnt[q.chan] = q.base_cnt[q.chan];
            n.cur_addr[q.chan] = q.base_addr[q.chan];
          end else begin
            n.mask[q.chan] = 1'b1;
          end
        end
        case (ch_md)
          DFDMA_MD_BLOCK: go_on = !at_tc;
          DFDMA_MD_DEMAND: go_on = !at_tc && q.req_s2[q.chan];
          default: go_on = 1'b0;
        endcase
        // single needs request low before next transfer
        if (ch_md == DFDMA_MD_SINGLE) begin
          n.wait_low[q.chan] = q.req_s2[q.chan];
          n.sw_req[q.chan] = 1'b0;
        end
        if (go_on) begin
          n.st = DFDMA_ST_ADDR;
        end else begin
          n.ack[q.chan] = 1'b0;
          n.hold_req = 1'b0;
          n.st = DFDMA_ST_IDLE;
        end
      end
      DFDMA_ST_CASC: begin
        // external master drives strobes; hold till request drops
        if (!q.req_s2[q.chan] && !q.sw_req[q.chan]) begin
          n.ack[q.chan] = 1'b0;
          n.hold_req = 1'b0;
          n.st = DFDMA_ST_IDLE;
        end
      end
      default: begin
        n.ack = 8'h00;
        n.hold_req = 1'b0;
        n.st = DFDMA_ST_IDLE;
      end
    endcase

    // float address while an external master owns the bus
    if (master) begin
      n.addr_oe = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= RST_Q;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_io_data = q.io_data;
  assign o_io_data_oe = q.io_data_oe;
  assign o_channel_acknowledge = q.ack;
  assign o_terminal_count = q.tc_out;
  assign o_hold_request = q.hold_req;
  assign o_address = q.addr;
  assign o_address_oe = q.addr_oe;
  assign o_io_read_strobe_n = q.ior_n;
  assign o_io_write_strobe_n = q.iow_n;
  assign o_memory_read_strobe_n = q.memory_read_strobe_n;
  assign o_memory_write_strobe_n = q.memory_write_strobe_n;
  assign o_strobe_oe = q.stb_oe;

endmodule

// ===== dfdma_properties.sv
`timescale 1ns/1ps

module dfdma_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // watched ports
  input wire logic [7:0] o_channel_acknowledge,
  input wire logic o_terminal_count,
  input wire logic o_hold_request,
  input wire logic i_hold_ack,
  input wire logic i_bus_master,
  input wire logic i_refresh_cycle_n,
  input wire logic o_address_oe,
  input wire logic o_io_read_strobe_n,
  input wire logic o_io_write_strobe_n,
  input wire logic o_memory_read_strobe_n,
  input wire logic o_memory_write_strobe_n,
  input wire logic o_strobe_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // service and grant
  // ----------------------------------------------------------------
  a_ack_onehot: assert property ($onehot0(o_channel_acknowledge))
    else $error("two acknowledges at once");
  a_ack_holds_bus: assert property (|o_channel_acknowledge |-> o_hold_request)
    else $error("acknowledge without bus request");
  a_ack_after_grant: assert property ($rose(|o_channel_acknowledge) |-> $past(i_hold_ack))
    else $error("acknowledge before grant");
  a_end_in_service: assert property (o_terminal_count |-> $past(|o_channel_acknowledge))
    else $error("count end outside service");

  // ----------------------------------------------------------------
  // strobes
  // ----------------------------------------------------------------
  a_mem_read_two: assert property ($fell(o_memory_read_strobe_n) |=>
    !o_memory_read_strobe_n ##1 o_memory_read_strobe_n)
    else $error("memory read strobe not two clocks");
  a_io_read_two: assert property ($fell(o_io_read_strobe_n) |=>
    !o_io_read_strobe_n ##1 o_io_read_strobe_n)
    else $error("io read strobe not two clocks");
  // extended write may start the write with the read, so allow one or two
  a_write_ends_read: assert property ($fell(o_io_write_strobe_n) |->
    !o_memory_read_strobe_n ##[1:2] (o_io_write_strobe_n && o_memory_read_strobe_n))
    else $error("write strobe outlives read strobe");
  a_no_clash: assert property (!(!o_memory_read_strobe_n && !o_memory_write_strobe_n) &&
    !(!o_io_read_strobe_n && !o_io_write_strobe_n))
    else $error("read and write strobes together");
  a_strobes_idle: assert property (!o_strobe_oe |->
    (o_io_read_strobe_n && o_io_write_strobe_n && o_memory_read_strobe_n &&
    o_memory_write_strobe_n))
    else $error("strobe low while not driving");

  // ----------------------------------------------------------------
  // address drive
  // ----------------------------------------------------------------
  a_master_float: assert property (i_bus_master [*4] |-> !o_address_oe)
    else $error("address driven under external master");
  a_refresh_drive: assert property ((!i_refresh_cycle_n && !i_bus_master) [*4] |-> o_address_oe)
    else $error("refresh address not driven");

  c_count_end: cover property (o_terminal_count);
  c_wide_ch1: cover property ($rose(o_channel_acknowledge[5]));
  c_refresh: cover property (!i_refresh_cycle_n && o_address_oe);
endmodule

bind dfdma_top dfdma_checker i_chk (.i_clk, .i_rst_n, .o_channel_acknowledge,
  .o_terminal_count, .o_hold_request, .i_hold_ack, .i_bus_master, .i_refresh_cycle_n,
  .o_address_oe, .o_io_read_strobe_n, .o_io_write_strobe_n, .o_memory_read_strobe_n,
  .o_memory_write_strobe_n, .o_strobe_oe);

// ===== dfdma_periph.sv
`timescale 1ns/1ps

module dfdma_periph (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // bench control
  input wire logic [7:0] i_want,
  input wire logic [2:0] i_lag,
  // device side
  input wire logic [7:0] i_ack,
  input wire logic i_hold_request,
  output logic [7:0] o_request,
  output logic o_hold_ack
);
  logic [7:0] got_q;
  logic [7:0] hold_q;

  // grant lags the bus request by a chosen number of clocks
  assign o_hold_ack = hold_q[i_lag];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_request <= '0;
      got_q <= '0;
      hold_q <= '0;
    end else begin
      hold_q <= {hold_q[6:0], i_hold_request};
      for (int i = 0; i < 8; i++) begin
        if (i_ack[i]) begin
          got_q[i] <= 1'b1;
        end
        if (got_q[i] && !i_ack[i]) begin
          o_request[i] <= 1'b0;
          got_q[i] <= 1'b0;
        end else if (i_want[i]) begin
          o_request[i] <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== dfdma_top_test.sv
`timescale 1ns/1ps

module dfdma_top_test;
  import dfdma_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] io_addr = '0;
  logic [7:0] io_data = '0;
  logic io_rd_n = 1'b1;
  logic io_wr_n = 1'b1;
  logic master = 1'b0;
  logic rfsh_n = 1'b1;
  logic [7:0] want = '0;
  logic [2:0] lag = 3'h0;
  logic [7:0] rdata, req, ack;
  logic [15:0] addr;
  logic rd_oe, ends_pulse, hold, hack, addr_oe, rd_io_n, wr_io_n, rd_mem_n, wr_mem_n, soe;
  logic soe_prev = 1'b0;
  logic [31:0] seed = 32'h0000_A67F;
  int num_errors = 0;
  int checked = 0;
  int xfers = 0;
  int ends = 0;
  int exp_q[$];

  dfdma_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_io_addr(io_addr), .i_io_data(io_data),
    .i_io_read_n(io_rd_n), .i_io_write_n(io_wr_n), .o_io_data(rdata), .o_io_data_oe(rd_oe),
    .i_channel_request(req), .o_channel_acknowledge(ack), .o_terminal_count(ends_pulse),
    .o_hold_request(hold), .i_hold_ack(hack), .i_bus_master(master),
    .i_refresh_cycle_n(rfsh_n), .o_address(addr), .o_address_oe(addr_oe),
    .o_io_read_strobe_n(rd_io_n), .o_io_write_strobe_n(wr_io_n),
    .o_memory_read_strobe_n(rd_mem_n), .o_memory_write_strobe_n(wr_mem_n), .o_strobe_oe(soe));
  dfdma_periph i_periph (.i_clk(clk), .i_rst_n(rst_n), .i_want(want), .i_lag(lag),
    .i_ack(ack), .i_hold_request(hold), .o_request(req), .o_hold_ack(hack));

  initial forever #2 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic fail(input string msg);
    $display("unexpected at %0t: %s", $time, msg);
    num_errors++;
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
  endtask
  task automatic cmp_addr(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("address %h, expected %h", got, exp));
  endtask
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_for(ref int cnt, input int n);
    int k;
    for (k = 0; k < 3000 && cnt < n; k++) tick(1);
    if (cnt < n) begin
      fail("wait ran out");
      report_and_stop();
    end
  endtask
  // the host port is synchronised, so strobes stay low and high for five clocks
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    io_addr = a;
    io_data = d;
    io_wr_n = 1'b0;
    tick(5);
    io_wr_n = 1'b1;
    tick(5);
  endtask
  task automatic io_rd(input logic [9:0] a, output logic [7:0] d);
    int n;
    io_addr = a;
    io_rd_n = 1'b0;
    for (n = 0; n < 20 && rd_oe !== 1'b1; n++) tick(1);
    if (n == 20) begin
      fail("no read answer");
      report_and_stop();
    end
    d = rdata;
    io_rd_n = 1'b1;
    tick(6);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    io_rd(a, d);
    cmp_reg(d, e);
  endtask
  task automatic prog(input int ch, input logic [7:0] md, input logic [15:0] a,
    input logic [15:0] c);
    logic [9:0] at;
    at = DFDMA_C2_BASE + 10'(ch * 4);
    io_wr(10'h0D8, 8'(rnd()));
    io_wr(10'h0D6, md);
    io_wr(at, a[7:0]);
    io_wr(at, a[15:8]);
    io_wr(at + 10'h002, c[7:0]);
    io_wr(at + 10'h002, c[15:8]);
  endtask

  // ----------------------------------------------------------------
  // transfer monitor
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (ends_pulse === 1'b1) ends++;
    if (soe === 1'b1 && soe_prev !== 1'b1) begin
      xfers++;
      if (exp_q.size() == 0) fail("transfer not expected");
      else cmp_addr(addr, 16'(exp_q.pop_front()));
    end
    soe_prev = soe;
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] a, b;
    logic [7:0] d;
    logic [8:0] r0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    rd_chk(10'h0D0, 8'h00);
    a = rnd();
    b = rnd() | 16'h0100;
    // single, read, autoinit on wide channel 1: two transfers per count of one
    prog(1, 8'h59, a, 16'h0001);
    rd_chk(10'h0C4, a[7:0]);
    rd_chk(10'h0C4, a[15:8]);
    want[5] = 1'b1;
    tick(30);
    cmp_reg({7'h00, hold}, 8'h00);
    exp_q.push_back(a);
    exp_q.push_back(a + 16'h0001);
    io_wr(10'h0D4, 8'h01);
    wait_for(ends, 1);
    want[5] = 1'b0;
    tick(30);
    cmp_reg(8'(xfers), 8'h02);
    rd_chk(10'h0D0, 8'h02);
    rd_chk(10'h0D0, 8'h00);
    io_wr(10'h0D8, 8'h00);
    rd_chk(10'h0C4, a[7:0]);
    rd_chk(10'h0C4, a[15:8]);
    // demand, write, decrement, no autoinit on wide channel 3 with a slow grant
    lag = 3'h5;
    prog(3, 8'h27, b, 16'h0002);
    exp_q.push_back(b);
    exp_q.push_back(b - 16'h0001);
    exp_q.push_back(b - 16'h0002);
    io_wr(10'h0DE, 8'h07);
    want[7] = 1'b1;
    wait_for(ends, 2);
    // drop the wish at once, or the model re-raises its request after the end
    want[7] = 1'b0;
    tick(40);
    cmp_reg(8'(xfers), 8'h05);
    io_rd(10'h0D0, d);
    cmp_reg(d & 8'h0F, 8'h08);
    io_wr(10'h0D8, 8'h00);
    rd_chk(10'h0CC, 8'(b - 16'h0003));
    // reinit sets masks and clears the byte pointer
    io_wr(10'h0DC, 8'(rnd()));
    io_wr(10'h0D8, 8'h00);
    io_wr(10'h0C4, 8'h5A);
    io_wr(10'h0DA, 8'(rnd()));
    rd_chk(10'h0C4, 8'h5A);
    want[5] = 1'b1;
    tick(40);
    cmp_reg({7'h00, hold}, 8'h00);
    exp_q.push_back({a[15:8], 8'h5A});
    io_wr(10'h0DC, 8'(rnd()));
    wait_for(xfers, 6);
    want[5] = 1'b0;
    tick(40);
    cmp_reg(8'(xfers), 8'h06);
    // block, verify, software request on masked wide channel 2
    prog(2, 8'h82, a, 16'h0001);
    io_wr(10'h0DE, 8'h0F);
    exp_q.push_back(a);
    exp_q.push_back(a + 16'h0001);
    io_wr(10'h0D2, 8'h06);
    wait_for(ends, 3);
    tick(40);
    cmp_reg(8'(xfers), 8'h08);
    rd_chk(10'h0D0, 8'h04);
    // narrow channel 1 reaches the bus through wide channel 0 in cascade
    io_wr(10'h0D6, 8'hC0);
    io_wr(10'h0D4, 8'h00);
    io_wr(10'h00C, 8'(rnd()));
    io_wr(10'h00B, 8'h49);
    io_wr(10'h002, a[7:0]);
    io_wr(10'h002, a[15:8]);
    io_wr(10'h003, 8'h00);
    io_wr(10'h003, 8'h00);
    io_wr(10'h00A, 8'h01);
    exp_q.push_back(a);
    want[1] = 1'b1;
    wait_for(ends, 4);
    want[1] = 1'b0;
    tick(40);
    cmp_reg(8'(xfers), 8'h09);
    rd_chk(10'h008, 8'h02);
    // refresh counter steps on each release of the refresh line
    rfsh_n = 1'b0;
    tick(6);
    r0 = addr[8:0];
    rfsh_n = 1'b1;
    tick(6);
    rfsh_n = 1'b0;
    tick(6);
    cmp_addr({7'h00, addr[8:0]}, {7'h00, r0 + 9'h001});
    master = 1'b1;
    tick(6);
    cmp_reg({7'h00, addr_oe}, 8'h00);
    master = 1'b0;
    rfsh_n = 1'b1;
    tick(6);
    report_and_stop();
  end
endmodule
